//--- logic/pwr_mode_defs.vh
`ifndef PWR_MODE_DEFS_VH
`define PWR_MODE_DEFS_VH

// register byte addresses on the bus
`define CSR_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define ADDR_W 12

// control_status_reg layout
`define PDF_MSB 15
`define PDF_LSB 10
`define GLOBAL_IRQ_EN_BIT 0
`define CSR_RESET 32'h00000000

// status register layout
`define ST_STATE_MSB 2
`define ST_STATE_LSB 0
`define ST_X4_BIT 3
`define ST_READY_BIT 4
`define ST_ARMED_BIT 5

// power_down_field codes
`define PD_NONE 6'h00
`define PD_HALT_EN 6'h09
`define PD_HALT_ANY 6'h11
`define PD_CLK_STOP 6'h1A
`define PD_PLL_STOP 6'h1C

// timing
`define CLK_PERIOD_NS 10
`define ENTRY_DELAY_CYC 4'h8
`define LOCK_TYP_NS 75000
`define LOCK_MARGIN_PCT 150
`define LOCK_MAX_NS (`LOCK_TYP_NS * (100 + `LOCK_MARGIN_PCT) / 100)
`define LOCK_MAX_CYC (`LOCK_MAX_NS / `CLK_PERIOD_NS)
`define LOCK_CNT_W 16

`endif

//--- logic/entry_delay.v
`timescale 1ns/10ps
`default_nettype none
`include "pwr_mode_defs.vh"

module entry_delay
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_start,
  input wire i_cancel,
  output wire o_fire,
  output wire o_busy
);

  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  // a restart while counting reloads, so the last write sets the moment
  always @*
  begin
    cnt_d = cnt_q;
    if (i_cancel)
    begin
      cnt_d = 4'h0;
    end
    else if (i_start)
    begin
      cnt_d = `ENTRY_DELAY_CYC;
    end
    else if (cnt_q != 4'h0)
    begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 4'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign o_fire = (cnt_q == 4'h1) && !i_start && !i_cancel;
  assign o_busy = (cnt_q != 4'h0);

endmodule

`default_nettype wire

//--- logic/clock_mode_power_down.v
`timescale 1ns/10ps
`default_nettype none
`include "pwr_mode_defs.vh"

// Operation
// - cpu clock is input clock times one when strap low, times four when high
// - the two upper straps are ignored; only the lowest strap picks the factor
// - mode and wake method come from control register bits 15 to 10
// - decode codes none, halt-enabled, halt-any, clock-tree stop, pll input stop
// - cpu halt takes effect eight to nine cycles after the field write
// - non-enabled interrupt wake resumes at halt point without servicing it
// - enabled interrupt wake runs the service routine, then resumes
// - service routine only when global and non-maskable enables are both set
// - clock-tree and pll input stop end only by device reset
// - cpu halt gates cpu clocks while interrupt logic stays clocked
// - dma path keeps running during cpu halt
// - clock-tree stop halts the pll output clock, stopping the whole chip
// - both stop modes keep register and memory contents
// - functional outputs freeze at their last level when the pll clock stops
// - pll input stop halts pll feed; relock wait follows the waking reset when the strap selects times four
// - all six field bits are read/write and reset to zero
module clock_mode_power_down
#(
  parameter LOCK_CYCLES = `LOCK_MAX_CYC
)
(
  input wire i_clock,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`ADDR_W-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  input wire i_pll_multiply_strap,
  input wire i_upper_strap_a,
  input wire i_upper_strap_b,
  input wire i_nonmaskable_enable_bit,
  input wire i_irq_enabled,
  input wire i_irq_non_enabled,
  output reg o_clock_multiply_x4,
  output reg o_clock_ready,
  output reg o_cpu_clock_enable,
  output reg o_irq_clock_enable,
  output reg o_dma_clock_enable,
  output reg o_pll_output_enable,
  output reg o_pll_input_enable,
  output reg o_io_freeze,
  output reg o_halted,
  output reg o_wake_service_irq,
  output reg o_wake_resume
);

  localparam ST_LOCK = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_ARM = 3'h2;
  localparam ST_HALT = 3'h3;
  localparam ST_CLK_STOP = 3'h4;
  localparam ST_PLL_STOP = 3'h5;

  localparam [31:0] LOCK_LAST_FULL = LOCK_CYCLES - 1;
  localparam [`LOCK_CNT_W-1:0] LOCK_LAST = LOCK_LAST_FULL[`LOCK_CNT_W-1:0];

  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [5:0] power_down_field_q;
  reg [5:0] power_down_field_d;
  reg global_irq_enable_q;
  reg global_irq_enable_d;
  reg [5:0] arm_code_q;
  reg [5:0] arm_code_d;
  reg strap_taken_q;
  reg [`LOCK_CNT_W-1:0] lock_cnt_q;
  reg [`LOCK_CNT_W-1:0] lock_cnt_d;
  reg service_d;
  reg resume_d;
  reg start_delay;
  reg cancel_delay;
  reg [31:0] rdata;

  wire csr_hit;
  wire status_hit;
  wire access;
  wire refused;
  wire csr_write;
  wire [5:0] wr_field;
  wire wr_is_entry;
  wire halt_wake;
  wire delay_fire;
  wire delay_busy;

  // reset is asserted at once and released through two flops
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // the strap is a level caught once after release, never under reset
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_taken_q <= 1'b0;
      o_clock_multiply_x4 <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      o_clock_multiply_x4 <= i_pll_multiply_strap;
    end
  end

  // bus decode; zero wait states
  assign csr_hit = (i_paddr == `CSR_OFFSET);
  assign status_hit = (i_paddr == `STATUS_OFFSET);
  assign access = i_psel && i_penable;
  // a stopped chip has no clock to take a write; lock wait likewise
  assign refused = (state_q == ST_CLK_STOP) || (state_q == ST_PLL_STOP) ||
                   (state_q == ST_LOCK);
  assign csr_write = access && i_pwrite && csr_hit && !refused;
  assign wr_field = i_pwdata[`PDF_MSB:`PDF_LSB];
  assign o_pready = 1'b1;
  assign o_pslverr = access && ((!csr_hit && !status_hit) ||
                                (i_pwrite && status_hit) ||
                                (i_pwrite && csr_hit && refused));

  // only the five listed codes exist; everything else is no power-down
  assign wr_is_entry = (wr_field == `PD_HALT_EN) || (wr_field == `PD_HALT_ANY) ||
                       (wr_field == `PD_CLK_STOP) ||
                       (wr_field == `PD_PLL_STOP);

  // halt-enabled code wakes only on an enabled interrupt; halt-any on either
  assign halt_wake = i_irq_enabled ||
                     ((arm_code_q == `PD_HALT_ANY) && i_irq_non_enabled);

  entry_delay u_entry_delay
  (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_start(start_delay),
    .i_cancel(cancel_delay),
    .o_fire(delay_fire),
    .o_busy(delay_busy)
  );

  always @*
  begin
    state_d = state_q;
    power_down_field_d = power_down_field_q;
    global_irq_enable_d = global_irq_enable_q;
    arm_code_d = arm_code_q;
    lock_cnt_d = lock_cnt_q;
    service_d = 1'b0;
    resume_d = 1'b0;
    start_delay = 1'b0;
    cancel_delay = 1'b0;
    case (state_q)
      ST_LOCK:
      begin
        // after every reset the multiplied clock needs relock time
        if (strap_taken_q)
        begin
          if (!o_clock_multiply_x4 || (lock_cnt_q == LOCK_LAST))
          begin
            state_d = ST_RUN;
          end
          else
          begin
            lock_cnt_d = lock_cnt_q + {{(`LOCK_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      ST_RUN, ST_ARM:
      begin
        if (delay_fire && (state_q == ST_ARM))
        begin
          if (arm_code_q == `PD_CLK_STOP)
          begin
            state_d = ST_CLK_STOP;
          end
          else if (arm_code_q == `PD_PLL_STOP)
          begin
            state_d = ST_PLL_STOP;
          end
          else
          begin
            state_d = ST_HALT;
          end
        end
        if (csr_write)
        begin
          // a later entry write replaces the pending request and restarts the delay; any other code cancels it
          if (wr_is_entry)
          begin
            state_d = ST_ARM;
            arm_code_d = wr_field;
            start_delay = 1'b1;
          end
          else
          begin
            state_d = ST_RUN;
            cancel_delay = 1'b1;
          end
        end
      end
      ST_HALT:
      begin
        if (halt_wake)
        begin
          state_d = ST_RUN;
          power_down_field_d = `PD_NONE;
          if (i_irq_enabled && global_irq_enable_q && i_nonmaskable_enable_bit)
          begin
            service_d = 1'b1;
          end
          else
          begin
            resume_d = 1'b1;
          end
        end
      end
      ST_CLK_STOP, ST_PLL_STOP:
      begin
        // no interrupt gets out of here; contents are left untouched
        state_d = state_q;
      end
      default:
      begin
        state_d = ST_LOCK;
      end
    endcase
    // a write in the wake cycle wins over the hardware clear
    if (csr_write)
    begin
      power_down_field_d = wr_field;
      global_irq_enable_d = i_pwdata[`GLOBAL_IRQ_EN_BIT];
    end
  end

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_LOCK;
      power_down_field_q <= `PD_NONE;
      global_irq_enable_q <= 1'b0;
      arm_code_q <= `PD_NONE;
      lock_cnt_q <= {`LOCK_CNT_W{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      power_down_field_q <= power_down_field_d;
      global_irq_enable_q <= global_irq_enable_d;
      arm_code_q <= arm_code_d;
      lock_cnt_q <= lock_cnt_d;
    end
  end

  // clock gates and freeze follow the next state so they line up with it
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_clock_ready <= 1'b0;
      o_cpu_clock_enable <= 1'b0;
      o_irq_clock_enable <= 1'b0;
      o_dma_clock_enable <= 1'b0;
      o_pll_output_enable <= 1'b1;
      o_pll_input_enable <= 1'b1;
      o_io_freeze <= 1'b0;
      o_halted <= 1'b0;
      o_wake_service_irq <= 1'b0;
      o_wake_resume <= 1'b0;
    end
    else
    begin
      o_clock_ready <= (state_d != ST_LOCK);
      o_cpu_clock_enable <= (state_d == ST_RUN) || (state_d == ST_ARM);
      o_irq_clock_enable <= (state_d == ST_RUN) || (state_d == ST_ARM) ||
                            (state_d == ST_HALT);
      o_dma_clock_enable <= (state_d == ST_RUN) || (state_d == ST_ARM) ||
                            (state_d == ST_HALT);
      o_pll_output_enable <= (state_d != ST_CLK_STOP);
      o_pll_input_enable <= (state_d != ST_PLL_STOP);
      o_io_freeze <= (state_d == ST_CLK_STOP) || (state_d == ST_PLL_STOP);
      o_halted <= (state_d == ST_HALT);
      o_wake_service_irq <= service_d;
      o_wake_resume <= resume_d;
    end
  end

  always @*
  begin
    rdata = 32'h00000000;
    if (csr_hit)
    begin
      rdata[`PDF_MSB:`PDF_LSB] = power_down_field_q;
      rdata[`GLOBAL_IRQ_EN_BIT] = global_irq_enable_q;
    end
    else if (status_hit)
    begin
      rdata[`ST_STATE_MSB:`ST_STATE_LSB] = state_q;
      rdata[`ST_X4_BIT] = o_clock_multiply_x4;
      rdata[`ST_READY_BIT] = o_clock_ready;
      rdata[`ST_ARMED_BIT] = delay_busy;
    end
  end

  // read data is captured in the setup cycle, ready for the access cycle
  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_prdata <= 32'h00000000;
    end
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      o_prdata <= rdata;
    end
  end

endmodule

`default_nettype wire

//--- tb/pd_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwr_mode_defs.vh"
module pd_chk
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_nonmaskable_enable_bit,
  input wire logic i_irq_enabled,
  input wire logic o_pslverr,
  input wire logic o_clock_multiply_x4,
  input wire logic o_clock_ready,
  input wire logic o_cpu_clock_enable,
  input wire logic o_irq_clock_enable,
  input wire logic o_dma_clock_enable,
  input wire logic o_pll_output_enable,
  input wire logic o_io_freeze,
  input wire logic o_halted,
  input wire logic o_wake_service_irq,
  input wire logic o_wake_resume
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  wire logic csr_wr;
  wire logic wr_ok;
  assign csr_wr = i_psel && i_penable && i_pwrite && i_paddr == `CSR_OFFSET;
  assign wr_ok = csr_wr && o_clock_ready && !o_io_freeze && !o_halted;
  // entry lands on the eighth or ninth edge after the committing write
  sequence s_enter(x);
    ##1 !x [*7] ##[1:2] x;
  endsequence
  AST_HALT_ENTRY: assert property (wr_ok && (i_pwdata[15:10] == `PD_HALT_EN
    || i_pwdata[15:10] == `PD_HALT_ANY) |-> s_enter(o_halted)) else $error("halt entry");
  AST_STOP_ENTRY: assert property (wr_ok && (i_pwdata[15:10] == `PD_CLK_STOP
    || i_pwdata[15:10] == `PD_PLL_STOP) |-> s_enter(o_io_freeze)) else $error("stop entry");
  AST_RSVD: assert property (wr_ok && i_pwdata[15:10] == 6'h1F
    |-> ##1 (o_cpu_clock_enable && !o_io_freeze) [*8]) else $error("reserved entered");
  AST_HALT_GATE: assert property (o_halted |-> !o_cpu_clock_enable && o_irq_clock_enable
    && o_dma_clock_enable) else $error("halt gating");
  AST_STOP_HOLD: assert property (o_io_freeze |=> o_io_freeze) else $error("stop left");
  AST_CLK_STOP: assert property (!o_pll_output_enable |-> o_io_freeze && !o_cpu_clock_enable
    && !o_dma_clock_enable) else $error("clock stop");
  AST_WAKE: assert property (o_halted && i_irq_enabled |=> !o_halted
    && $rose(o_wake_service_irq || o_wake_resume)) else $error("wake");
  AST_PULSE: assert property (o_wake_service_irq || o_wake_resume
    |=> !o_wake_service_irq && !o_wake_resume) else $error("pulse width");
  AST_SVC_NONMASKABLE_ENABLE_BIT: assert property (o_wake_service_irq
    |-> $past(i_nonmaskable_enable_bit)) else $error("service gate");
  AST_LOCK_ERR: assert property (csr_wr && !o_clock_ready |-> o_pslverr)
    else $error("lock write");
  AST_X4: assert property (o_clock_ready |-> $stable(o_clock_multiply_x4))
    else $error("factor moved");
endmodule
bind clock_mode_power_down pd_chk chk (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .i_nonmaskable_enable_bit, .i_irq_enabled, .o_pslverr,
  .o_clock_multiply_x4, .o_clock_ready, .o_cpu_clock_enable, .o_irq_clock_enable,
  .o_dma_clock_enable, .o_pll_output_enable, .o_io_freeze, .o_halted, .o_wake_service_irq,
  .o_wake_resume);
`default_nettype wire

//--- tb/irq_source.sv
`timescale 1ns/10ps
`default_nettype none
module irq_source
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_raise_en,
  input wire logic i_raise_non,
  input wire logic i_ack,
  output var logic o_irq_enabled,
  output var logic o_irq_non_enabled
);
  // requests are levels: they pend until the core takes a wake, so a stop mode keeps them up
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_irq_enabled <= 1'b0;
      o_irq_non_enabled <= 1'b0;
    end
    else if (i_ack)
    begin
      o_irq_enabled <= 1'b0;
      o_irq_non_enabled <= 1'b0;
    end
    else
    begin
      if (i_raise_en)
        o_irq_enabled <= 1'b1;
      if (i_raise_non)
        o_irq_non_enabled <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/clock_mode_and_power_down_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwr_mode_defs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module clock_mode_and_power_down_tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, strap = 1, ua = 1, ub = 0, nonmaskable_enable_bit = 0;
  logic r_en = 0, r_non = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  wire logic pready, pslverr, x4, rdy, cpu_en, irq_ck, dma_en, pllo, plli, frz, hlt, svc, res;
  wire logic irq_en, irq_non;
  wire logic [31:0] prdata;
  int n_errors = 0, comparisons = 0, cyc = 0;
  clock_mode_power_down #(.LOCK_CYCLES(20)) dut (.i_clock(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_pll_multiply_strap(strap),
    .i_upper_strap_a(ua), .i_upper_strap_b(ub), .i_nonmaskable_enable_bit(nonmaskable_enable_bit),
    .i_irq_enabled(irq_en), .i_irq_non_enabled(irq_non), .o_clock_multiply_x4(x4),
    .o_clock_ready(rdy), .o_cpu_clock_enable(cpu_en), .o_irq_clock_enable(irq_ck),
    .o_dma_clock_enable(dma_en), .o_pll_output_enable(pllo), .o_pll_input_enable(plli),
    .o_io_freeze(frz), .o_halted(hlt), .o_wake_service_irq(svc), .o_wake_resume(res));
  irq_source ps (.i_clock(clk), .i_rst_n(rst_n), .i_raise_en(r_en), .i_raise_non(r_non),
    .i_ack(svc | res), .o_irq_enabled(irq_en), .o_irq_non_enabled(irq_non));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      print_verdict;
    end
  end
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task wait_halt(input logic v);
    repeat (12) if (hlt !== v) @(posedge clk);
  endtask
  task pulse_wait;
    repeat (6) if (svc !== 1'b1 && res !== 1'b1) @(posedge clk);
  endtask
  // strap low skips the lock wait, so the early write is taken then
  task do_reset(input logic s);
    strap <= s;
    ua <= !s;
    ub <= !s;
    rst_n <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (6) @(posedge clk);
    bus(1, `CSR_OFFSET, {16'h0000, (s ? `PD_HALT_EN : `PD_NONE), 9'h000, 1'b1});
    `CHK("lock write", s, e);
    `CHK("lock wait", !s, rdy);
    repeat (40) if (rdy !== 1'b1) @(posedge clk);
    `CHK("ready", 1'b1, rdy);
    `CHK("x4", s, x4);
    bus(0, `CSR_OFFSET, 0);
    `CHK("csr reset", s ? `CSR_RESET : 32'h00000001, q);
  endtask
  task t_rsvd;
    bus(1, `CSR_OFFSET, 32'h00007C01);
    repeat (12) @(posedge clk);
    `CHK("no entry", 4'b1000, {cpu_en, hlt, frz, !pllo});
    bus(0, `CSR_OFFSET, 0);
    `CHK("field rw", 32'h00007C01, q);
    bus(1, 12'h008, 0);
    `CHK("unmapped", 1'b1, e);
    bus(1, `STATUS_OFFSET, 0);
    `CHK("ro status", 1'b1, e);
    bus(1, `CSR_OFFSET, 0);
  endtask
  task t_halt(input logic [5:0] code, input logic global_irq_enable, input logic nm, input logic svc_exp);
    nonmaskable_enable_bit <= nm;
    bus(1, `CSR_OFFSET, {16'h0000, code, 9'h000, global_irq_enable});
    wait_halt(1);
    `CHK("halted", 1'b1, hlt);
    `CHK("gates", 3'b011, {cpu_en, irq_ck, dma_en});
    r_non <= 1;
    @(posedge clk);
    r_non <= 0;
    pulse_wait;
    if (code == `PD_HALT_EN)
    begin
      `CHK("still halted", 1'b1, hlt);
      r_en <= 1;
      @(posedge clk);
      r_en <= 0;
      pulse_wait;
    end
    `CHK("wake kind", {svc_exp, !svc_exp}, {svc, res});
    wait_halt(0);
    bus(0, `CSR_OFFSET, 0);
    `CHK("awake", 7'h00, {hlt, q[15:10]});
  endtask
  task t_stop(input logic [5:0] code);
    bus(1, `CSR_OFFSET, {16'h0000, code, 10'h000});
    repeat (10) if (frz !== 1'b1) @(posedge clk);
    `CHK("freeze", 1'b1, frz);
    `CHK("pll gate", 1'b0, code == `PD_CLK_STOP ? pllo : plli);
    r_en <= 1;
    @(posedge clk);
    r_en <= 0;
    repeat (8) @(posedge clk);
    `CHK("stays stopped", 1'b1, frz);
    bus(0, `CSR_OFFSET, 0);
    `CHK("kept", code, q[15:10]);
    do_reset(code == `PD_PLL_STOP);
    `CHK("out of stop", 3'b110, {pllo, plli, frz});
  endtask
  initial
  begin
    do_reset(1'b1);
    t_rsvd;
    t_halt(`PD_HALT_EN, 1'b1, 1'b1, 1'b1);
    t_halt(`PD_HALT_EN, 1'b1, 1'b0, 1'b0);
    t_halt(`PD_HALT_EN, 1'b0, 1'b1, 1'b0);
    t_halt(`PD_HALT_ANY, 1'b1, 1'b1, 1'b0);
    t_stop(`PD_CLK_STOP);
    t_stop(`PD_PLL_STOP);
    print_verdict;
  end
endmodule
`default_nettype wire
